// ### nvs_host.sv
// Purpose: AXI4-Lite master standing in for the core or debug controller
// Assumes: one write or one read at a time, driven after rising edges
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module nvs_host (
	// clock
	input wire logic aclk,
	// write channels
	output logic awvalid,
	input wire logic awready,
	output logic [11:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic arvalid,
	input wire logic arready,
	output logic [11:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	int tmo = 0;
	logic [1:0] lr;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
	end
	// bready rises with the request: the answer may follow both words at once
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 99 && !bvalid; n++) begin
			@(posedge aclk);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
			awaddr <= awready ? ~a : awaddr;
			wdata <= wready ? ~d : wdata;
		end
		bready <= 1'b0;
		tmo += int'(n == 99);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 99 && !rvalid; n++) begin
			@(posedge aclk);
			arvalid <= arvalid && !arready;
			araddr <= arready ? ~a : araddr;
		end
		d = rdata;
		lr = rresp;
		rready <= 1'b0;
		tmo += int'(n == 99);
	endtask
endmodule
`default_nettype wire

// ### nvs_pkg.sv
// Purpose: shared constants and types of the program/erase sequencer
// Assumes: AXI4-Lite register access, one aligned word per register
// Notes: all command codes, offsets, field positions and tick counts live here
package nvs_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_DIV = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CMD = 12'h008;
	localparam logic [11:0] OFS_ARR = 12'h00C;
	// status and divider fields
	localparam int ST_CBEF = 7;
	localparam int ST_CCF = 6;
	localparam int ST_ERR = 4;
	localparam int DIV_SET_BIT = 7;
	// array-write word: data, offset within array, array select
	localparam int ARR_OFS_LSB = 8;
	localparam int ARR_OFS_MSB = 24;
	localparam int ARR_SEL_BIT = 31;
	localparam int BLK_LSB = 5;
	// command codes
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_SECTOR = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;
	localparam logic [7:0] CMD_ABORT = 8'h47;
	// durations in timing-clock periods
	localparam int TK_BYTE = 9;
	localparam int TK_BURST = 4;
	localparam int TK_ABORT = 4;
	localparam int TK_BLANK = 9;
	localparam int TK_SECTOR = 4000;
	localparam int TK_MASS = 20000;
	// reset values and response codes
	localparam logic RST_CBEF = 1'b1;
	localparam logic RST_CCF = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARR, SEQ_CMD} nvs_seq_type;

	typedef struct packed {
		logic [7:0] cmd;
		logic [17:0] addr;
		logic [7:0] data;
	} nvs_op_type;

	typedef struct packed {
		logic aw_v;
		logic [11:0] aw_a;
		logic w_v;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic div_set;
		logic [6:0] div;
		logic [6:0] presc;
		nvs_seq_type seq;
		logic err;
		logic cbef;
		logic ccf;
		nvs_op_type lat;
		nvs_op_type pend;
		nvs_op_type run;
		logic pend_v;
		logic busy;
		logic pump;
		logic aborting;
		logic abort_hit;
		logic [14:0] rem;
	} nvs_state_type;
endpackage

// ### nvs_sequencer.sv
// Purpose: program/erase command sequencer with AXI4-Lite registers
// Assumes: all inputs come from the aclk domain
// Notes: array side sees only the running operation, busy and pump enable
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - a sequence opens with one array write, its address and data latched
// - erase and blank check ignore data; any address in sector or array
// - blank check 0x05, byte program 0x20, burst program 0x25 are decoded
// - sector erase 0x40, mass erase 0x41, sector erase abort 0x47 decoded
// - writing 1 to buffer-empty launches the buffered command; it stays clear only while queued behind a busy one or for abort
// - writing 0 to buffer-empty mid-sequence cancels it and sets error
// - complete flag sets when the launched operation finishes
// - burst keeps pump only if next burst queued in the same 32-byte block
// - first burst byte standard time, later ones burst time; else pump off
// - abort sequence array write is ignored; abort ends an active sector erase
// - abort launched during an active sector erase sets error at completion, else not
// - buffer-empty stays clear after abort launch; new sequence then errors
// - error cleared only by writing 1; while set no command is processed
// - array write with buffer busy or divider unwritten sets error
// - second array write or second command write before launch sets error
// - after array write, a write to divider or status sets error
// - command code outside the six valid ones sets error
// - after command write, any register access but launch or an array-register read sets error
// - stop mode during an operation aborts it and sets error
// - secured debug port may only issue blank check and mass erase
// - flash and eeprom arrays are erased independently
// - divider is write-once and sets the timing clock
// - pulses are timed in whole periods of the timing clock
module nvs_sequencer #(
	parameter int SECTOR_TICKS = nvs_pkg::TK_SECTOR,
	parameter int MASS_TICKS = nvs_pkg::TK_MASS
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// system state
	input wire logic stop_mode,
	input wire logic secured,
	input wire logic debug_port,
	// array side
	output nvs_pkg::nvs_op_type nv_op,
	output logic nv_busy,
	output logic nv_pump_on
);
	nvs_pkg::nvs_state_type s, n;
	logic wr_go, rd_go, wst, tick, done, keep, err_set;
	logic [11:0] wa;
	logic [7:0] stat;

	function automatic logic code_ok(input logic [7:0] c);
		return c == nvs_pkg::CMD_BLANK || c == nvs_pkg::CMD_BYTE ||
			c == nvs_pkg::CMD_BURST || c == nvs_pkg::CMD_SECTOR ||
			c == nvs_pkg::CMD_MASS || c == nvs_pkg::CMD_ABORT;
	endfunction

	// remaining periods minus one; the run ends on the tick at zero
	function automatic logic [14:0] ticks(input logic [7:0] c,
		input logic fast);
		case (c)
			nvs_pkg::CMD_BYTE: ticks = 15'(nvs_pkg::TK_BYTE - 1);
			nvs_pkg::CMD_BURST: ticks = fast ?
				15'(nvs_pkg::TK_BURST - 1) : 15'(nvs_pkg::TK_BYTE - 1);
			nvs_pkg::CMD_SECTOR: ticks = 15'(SECTOR_TICKS - 1);
			nvs_pkg::CMD_MASS: ticks = 15'(MASS_TICKS - 1);
			nvs_pkg::CMD_ABORT: ticks = 15'(nvs_pkg::TK_ABORT - 1);
			default: ticks = 15'(nvs_pkg::TK_BLANK - 1);
		endcase
	endfunction

	assign wr_go = s.aw_v && s.w_v && !s.bvalid;
	assign wst = wr_go && s.w_s[0];
	assign wa = s.aw_a;
	assign rd_go = arvalid && !s.rvalid;
	assign done = s.busy && tick && s.rem == 15'h0000;
	assign keep = s.run.cmd == nvs_pkg::CMD_BURST &&
		s.pend.cmd == nvs_pkg::CMD_BURST && s.pend_v &&
		s.pend.addr[17:nvs_pkg::BLK_LSB] == s.run.addr[17:nvs_pkg::BLK_LSB];

	always_comb begin
		stat = 8'h00;
		stat[nvs_pkg::ST_CBEF] = s.cbef;
		stat[nvs_pkg::ST_CCF] = s.ccf;
		stat[nvs_pkg::ST_ERR] = s.err;
	end

	always_comb begin
		n = s;
		tick = 1'b0;
		err_set = 1'b0;
		// bus channels: address and data captured in either order
		if (awvalid && !s.aw_v && !s.bvalid) begin
			n.aw_v = 1'b1;
			n.aw_a = awaddr;
		end
		if (wvalid && !s.w_v && !s.bvalid) begin
			n.w_v = 1'b1;
			n.w_d = wdata;
			n.w_s = wstrb;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (s.rvalid && rready)
			n.rvalid = 1'b0;

		// timing clock prescaler, restarted between operations
		if (s.busy && s.div_set) begin
			if (s.presc == s.div) begin
				n.presc = 7'h00;
				tick = 1'b1;
			end else begin
				n.presc = s.presc + 7'h01;
			end
		end else begin
			n.presc = 7'h00;
		end
		if (s.busy && tick && s.rem != 15'h0000)
			n.rem = s.rem - 15'h0001;
		// pump comes up on the first tick unless carried over; never for blank check or abort
		if (s.busy && tick && s.run.cmd != nvs_pkg::CMD_BLANK &&
			s.run.cmd != nvs_pkg::CMD_ABORT)
			n.pump = 1'b1;

		if (done) begin
			if (s.abort_hit)
				err_set = 1'b1;
			n.aborting = 1'b0;
			n.abort_hit = 1'b0;
			if (s.pend_v) begin
				n.pend_v = 1'b0;
				n.run = s.pend;
				n.rem = ticks(s.pend.cmd, keep);
				n.pump = keep;
				n.cbef = s.pend.cmd != nvs_pkg::CMD_ABORT;
				n.aborting = s.pend.cmd == nvs_pkg::CMD_ABORT;
			end else begin
				n.busy = 1'b0;
				n.pump = 1'b0;
				n.ccf = 1'b1;
				n.cbef = 1'b1;
			end
		end

		if (wr_go) begin
			n.aw_v = 1'b0;
			n.w_v = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wa > nvs_pkg::OFS_ARR ?
				nvs_pkg::RESP_SLVERR : nvs_pkg::RESP_OKAY;
		end
		if (wst) begin
			case (wa)
				nvs_pkg::OFS_ARR: if (!s.err) begin
					if (!s.div_set || !s.cbef || s.seq != nvs_pkg::SEQ_IDLE)
						err_set = 1'b1;
					else begin
						n.lat.data = s.w_d[7:0];
						n.lat.addr = {s.w_d[nvs_pkg::ARR_SEL_BIT],
							s.w_d[nvs_pkg::ARR_OFS_MSB:nvs_pkg::ARR_OFS_LSB]};
						n.seq = nvs_pkg::SEQ_ARR;
					end
				end
				nvs_pkg::OFS_CMD: if (!s.err &&
					s.seq != nvs_pkg::SEQ_IDLE) begin
					if (s.seq == nvs_pkg::SEQ_CMD || !code_ok(s.w_d[7:0]))
						err_set = 1'b1;
					else if (secured && debug_port &&
						s.w_d[7:0] != nvs_pkg::CMD_BLANK &&
						s.w_d[7:0] != nvs_pkg::CMD_MASS)
						err_set = 1'b1;
					else begin
						n.lat.cmd = s.w_d[7:0];
						n.seq = nvs_pkg::SEQ_CMD;
					end
				end
				nvs_pkg::OFS_STAT: begin
					if (s.w_d[nvs_pkg::ST_ERR])
						n.err = 1'b0;
					if (!s.err && s.seq != nvs_pkg::SEQ_IDLE) begin
						if (s.seq == nvs_pkg::SEQ_CMD &&
							s.w_d[nvs_pkg::ST_CBEF]) begin
							n.seq = nvs_pkg::SEQ_IDLE;
							n.ccf = 1'b0;
							n.cbef = 1'b0;
							if (s.lat.cmd == nvs_pkg::CMD_ABORT) begin
								n.lat.addr = 18'h00000;
								n.lat.data = 8'h00;
							end
							if (s.lat.cmd == nvs_pkg::CMD_ABORT && n.busy &&
								n.run.cmd == nvs_pkg::CMD_SECTOR) begin
								n.aborting = 1'b1;
								n.abort_hit = 1'b1;
								if (n.rem > 15'(nvs_pkg::TK_ABORT - 1))
									n.rem = 15'(nvs_pkg::TK_ABORT - 1);
							end else if (n.busy) begin
								n.pend_v = 1'b1;
								n.pend = n.lat;
							end else begin
								// erase and blank check carry the latched data as well as the address
								n.busy = 1'b1;
								n.run = n.lat;
								n.rem = ticks(s.lat.cmd, 1'b0);
								n.pump = 1'b0;
								n.cbef = s.lat.cmd != nvs_pkg::CMD_ABORT;
								n.aborting = s.lat.cmd == nvs_pkg::CMD_ABORT;
							end
						end else begin
							err_set = 1'b1;
						end
					end
				end
				nvs_pkg::OFS_DIV: begin
					if (!s.err && s.seq != nvs_pkg::SEQ_IDLE)
						err_set = 1'b1;
					else if (!s.div_set) begin
						n.div_set = 1'b1;
						n.div = s.w_d[6:0];
					end
				end
				default: ;
			endcase
		end

		if (rd_go) begin
			n.rvalid = 1'b1;
			n.rresp = nvs_pkg::RESP_OKAY;
			case (araddr)
				nvs_pkg::OFS_DIV: n.rdata = {24'h000000, s.div_set, s.div};
				nvs_pkg::OFS_STAT: n.rdata = {24'h000000, stat};
				nvs_pkg::OFS_CMD: n.rdata = {24'h000000, s.lat.cmd};
				nvs_pkg::OFS_ARR: n.rdata = {s.lat.addr[17], 6'h00,
					s.lat.addr[16:0], s.lat.data};
				default: begin
					n.rdata = 32'h00000000;
					n.rresp = nvs_pkg::RESP_SLVERR;
				end
			endcase
			if (!s.err && s.seq == nvs_pkg::SEQ_CMD &&
				araddr != nvs_pkg::OFS_ARR && araddr <= nvs_pkg::OFS_ARR)
				err_set = 1'b1;
		end

		if (stop_mode && s.busy) begin
			n.busy = 1'b0;
			n.pump = 1'b0;
			n.pend_v = 1'b0;
			n.aborting = 1'b0;
			n.abort_hit = 1'b0;
			n.ccf = 1'b1;
			n.cbef = 1'b1;
			err_set = 1'b1;
		end
		// a fresh error wins over a same-cycle clear
		if (err_set) begin
			n.err = 1'b1;
			n.seq = nvs_pkg::SEQ_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.cbef <= nvs_pkg::RST_CBEF;
			s.ccf <= nvs_pkg::RST_CCF;
		end else if (ce) begin
			s <= n;
		end
	end

	// no word is taken while frozen, else the handshake would be lost
	assign awready = ce && !s.aw_v && !s.bvalid;
	assign wready = ce && !s.w_v && !s.bvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = ce && !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign nv_op = s.run;
	assign nv_busy = s.busy;
	assign nv_pump_on = s.pump;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic launch_ev;
	assign launch_ev = ce && wst && wa == nvs_pkg::OFS_STAT && !s.err &&
		s.w_d[nvs_pkg::ST_CBEF] && s.seq == nvs_pkg::SEQ_CMD;

	a_launch_ccf_low: assert property (launch_ev && !stop_mode |=> !s.ccf)
		else $error("launch did not clear complete flag");
	a_busy_not_done: assert property (s.busy |-> !s.ccf)
		else $error("complete flag set while busy");
	a_cancel_error: assert property (ce && wst && wa == nvs_pkg::OFS_STAT &&
		!s.err && !s.w_d[nvs_pkg::ST_CBEF] && s.seq != nvs_pkg::SEQ_IDLE
		|=> s.err && s.seq == nvs_pkg::SEQ_IDLE)
		else $error("cancel did not flag error");
	a_bad_code_err: assert property (ce && wst && wa == nvs_pkg::OFS_CMD &&
		!s.err && s.seq == nvs_pkg::SEQ_ARR && !code_ok(s.w_d[7:0])
		|=> s.err)
		else $error("invalid code accepted");
	a_err_sticky: assert property (ce && s.err && !(wst &&
		wa == nvs_pkg::OFS_STAT && s.w_d[nvs_pkg::ST_ERR]) |=> s.err)
		else $error("error flag dropped without clear");
	a_err_blocks: assert property (s.err |-> s.seq == nvs_pkg::SEQ_IDLE)
		else $error("sequence advanced with error set");
	a_div_once: assert property (ce && s.div_set
		|=> s.div_set && $stable(s.div))
		else $error("divider changed after first write");
	a_stop_abort: assert property (ce && stop_mode && s.busy
		|=> !s.busy && s.err)
		else $error("stop did not abort operation");
	a_abort_no_cbef: assert property (s.aborting |-> !s.cbef)
		else $error("buffer empty set during abort");
	a_arr_no_div: assert property (ce && wst && wa == nvs_pkg::OFS_ARR &&
		!s.div_set |=> s.err)
		else $error("array write before divider accepted");

	c_launch: cover property (launch_ev);
	c_burst_keep: cover property (done && keep);
	c_abort_hit: cover property (done && s.abort_hit);
	c_stop: cover property (ce && stop_mode && s.busy);
endmodule

`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench of the program/erase sequencer
// Assumes: divider 3, so one timing tick every four clocks
// Notes: erase counts shortened so the whole run stays brief
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic stop_mode = 1'b0, secured = 1'b0, debug_port = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
	logic arready, rvalid, rready, nv_busy, nv_pump_on;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv, rs = 32'hF162;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	nvs_pkg::nvs_op_type nv_op;
	int err_total = 0;
	int checked = 0;
	always #20 aclk = ~aclk;
	nvs_sequencer #(.SECTOR_TICKS(6), .MASS_TICKS(8)) dut (
		.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .stop_mode,
		.secured, .debug_port, .nv_op, .nv_busy, .nv_pump_on
	);
	nvs_host host (
		.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp
	);
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// running operation as {eeprom select, offset, data} from an array word
	function automatic logic [31:0] at_exp(input logic [31:0] w);
		return {6'h00, w[31], w[24:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict();
		err_total += host.tmo;
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic seq(input logic [7:0] c, input logic [31:0] a);
		host.wr(nvs_pkg::OFS_ARR, a);
		host.wr(nvs_pkg::OFS_CMD, {24'h0, c});
		host.wr(nvs_pkg::OFS_STAT, 32'h80);
	endtask
	task automatic wdone();
		int n;
		for (n = 0; n < 200; n++) begin
			host.rd(nvs_pkg::OFS_STAT, rv);
			if (rv[nvs_pkg::ST_CCF] === 1'b1) break;
		end
		if (n == 200) begin
			err_total++;
			print_verdict();
		end
	endtask
	// the error flag is cleared here when it is expected set, so every case starts from a clean flag
	task automatic ec(input logic e);
		host.rd(nvs_pkg::OFS_STAT, rv);
		chk("err", {31'h0, rv[nvs_pkg::ST_ERR]}, {31'h0, e});
		if (e)
			host.wr(nvs_pkg::OFS_STAT, 32'h1 << nvs_pkg::ST_ERR);
	endtask
	initial begin
		logic [31:0] a;
		int n;
		static logic [7:0] ok [5] = '{nvs_pkg::CMD_BLANK, nvs_pkg::CMD_BYTE,
			nvs_pkg::CMD_BURST, nvs_pkg::CMD_SECTOR, nvs_pkg::CMD_MASS};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		host.rd(nvs_pkg::OFS_STAT, rv);
		chk("stat", rv, 32'hC0);
		host.wr(nvs_pkg::OFS_ARR, xs());
		host.wr(nvs_pkg::OFS_STAT, 32'h0);
		seq(nvs_pkg::CMD_BYTE, xs());
		chk("busy", {31'h0, nv_busy}, 32'h0);
		ec(1'b1);
		ec(1'b0);
		host.wr(nvs_pkg::OFS_DIV, 32'h3);
		host.wr(nvs_pkg::OFS_DIV, 32'h7);
		host.rd(nvs_pkg::OFS_DIV, rv);
		chk("div", rv, 32'h3 | (32'h1 << nvs_pkg::DIV_SET_BIT));
		host.rd(12'h010, rv);
		chk("rresp", {30'h0, host.lr}, {30'h0, nvs_pkg::RESP_SLVERR});
		host.wr(12'h010, 32'h0);
		chk("bresp", {30'h0, bresp}, {30'h0, nvs_pkg::RESP_SLVERR});
		// no strobe: must not open a sequence, or the next one errors
		host.wr(nvs_pkg::OFS_ARR, xs(), 4'h0);
		chk("bresp", {30'h0, bresp}, {30'h0, nvs_pkg::RESP_OKAY});
		foreach (ok[i]) begin
			a = xs() & 32'h81FF_FFFF;
			seq(ok[i], a);
			chk("cmd", {24'h0, nv_op.cmd}, {24'h0, ok[i]});
			chk("at", {6'h0, nv_op[25:0]}, at_exp(a));
			chk("busy", {31'h0, nv_busy}, 32'h1);
			host.rd(nvs_pkg::OFS_ARR, rv);
			chk("arr", rv, a);
			host.rd(nvs_pkg::OFS_CMD, rv);
			chk("cmdreg", rv, {24'h0, ok[i]});
			wdone();
			chk("pump", {31'h0, nv_pump_on}, 32'h0);
			ec(1'b0);
		end
		for (n = 0; n < 6; n++) begin
			host.wr(nvs_pkg::OFS_ARR, xs());
			case (n)
				0: host.wr(nvs_pkg::OFS_CMD, 32'h33);
				1: host.wr(nvs_pkg::OFS_STAT, 32'h0);
				2: host.wr(nvs_pkg::OFS_ARR, xs());
				3: begin
					host.wr(nvs_pkg::OFS_CMD, 32'h20);
					host.wr(nvs_pkg::OFS_CMD, 32'h20);
				end
				4: begin
					host.wr(nvs_pkg::OFS_CMD, 32'h20);
					host.rd(nvs_pkg::OFS_STAT, rv);
				end
				default: host.wr(nvs_pkg::OFS_DIV, 32'h3);
			endcase
			ec(1'b1);
		end
		secured <= 1'b1;
		debug_port <= 1'b1;
		seq(nvs_pkg::CMD_BYTE, xs());
		ec(1'b1);
		seq(nvs_pkg::CMD_MASS, xs());
		wdone();
		ec(1'b0);
		secured <= 1'b0;
		debug_port <= 1'b0;
		seq(nvs_pkg::CMD_SECTOR, xs());
		stop_mode <= 1'b1;
		repeat (2) @(posedge aclk);
		stop_mode <= 1'b0;
		chk("busy", {31'h0, nv_busy}, 32'h0);
		ec(1'b1);
		seq(nvs_pkg::CMD_SECTOR, xs());
		seq(nvs_pkg::CMD_ABORT, xs());
		wdone();
		ec(1'b1);
		seq(nvs_pkg::CMD_ABORT, xs());
		host.rd(nvs_pkg::OFS_STAT, rv);
		chk("cbef", {31'h0, rv[nvs_pkg::ST_CBEF]}, 32'h0);
		wdone();
		ec(1'b0);
		seq(nvs_pkg::CMD_ABORT, xs());
		host.wr(nvs_pkg::OFS_ARR, xs());
		wdone();
		ec(1'b1);
		// second byte queued while the first runs, same 32-byte block
		a = xs() & 32'h01FF_E0FF;
		seq(nvs_pkg::CMD_BURST, a);
		seq(nvs_pkg::CMD_BURST, a + 32'h100);
		for (n = 0; n < 99 && nv_op.addr[0] !== 1'b1; n++)
			@(posedge aclk);
		if (n == 99) begin
			err_total++;
			print_verdict();
		end
		chk("pump", {31'h0, nv_pump_on}, 32'h1);
		wdone();
		chk("pump", {31'h0, nv_pump_on}, 32'h0);
		ec(1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
